// *** pkg/supply_monitor_pkg.sv ***
package supply_monitor_pkg;
   localparam logic [11:0] ctrl_addr = 12'h000;
   localparam logic [11:0] irq_addr = 12'h004;
   localparam int level_lsb = 0;
   localparam int enable_bit = 4;
   localparam int stable_bit = 5;
   localparam int flag_bit = 0;
   localparam int irq_en_bit = 1;
   localparam int global_en_bit = 2;
   localparam logic [3:0] level_reset = 4'h5;
   localparam logic [3:0] level_external = 4'hf;
   localparam logic [3:0] level_4v5 = 4'he;
   localparam logic [3:0] level_4v2 = 4'hd;
   localparam int settle_time_ns = 20000;
   localparam int clk_period_ns = 10;
   localparam int settle_cycles = (settle_time_ns + clk_period_ns - 1) / clk_period_ns;
   localparam int settle_width = 16;
   typedef enum logic [1:0]
   {
      mon_off = 2'b00,
      mon_settle = 2'b01,
      mon_ready = 2'b10
   } mon_state_type;
endpackage

// *** rtl/settle_timer.sv ***
module settle_timer
   import supply_monitor_pkg::*;
#(
   parameter logic [settle_width-1:0] cycles = settle_width'(settle_cycles)
)
(
   input wire logic clk, // System clock.
   input wire logic reset_n, // Asynchronous reset, active low.
   input wire logic run, // Count while high, clear while low.
   output logic done // High once the count has elapsed.
);
   typedef struct packed
   {
      logic [settle_width-1:0] count;
      logic done;
   } timer_type;
   timer_type state_r;
   timer_type state_nxt;

   // Fixed-time counter, so the wait does not depend on any clock divider.
   always_comb
   begin
      state_nxt = state_r;
      if (!run)
      begin
         state_nxt.count = '0;
         state_nxt.done = 1'b0;
      end
      else if (state_r.count == cycles - settle_width'(1))
      begin
         state_nxt.done = 1'b1;
      end
      else
      begin
         state_nxt.count = state_r.count + settle_width'(1);
      end
   end

   // State register.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign done = state_r.done;
endmodule

// *** rtl/supply_monitor.sv ***
// Our own choices: the APB slave port and the register addresses.
module supply_monitor
   import supply_monitor_pkg::*;
#(
   parameter logic [settle_width-1:0] settle_count = settle_width'(settle_cycles)
)
(
   input wire logic clk, // System clock, 100 MHz.
   input wire logic reset_n, // Asynchronous reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB access phase.
   input wire logic pwrite, // APB write.
   input wire logic [11:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error for unmapped address.
   input wire logic comp_below, // Comparator: selected input below reference.
   input wire logic external_trip_input, // External trip pin level reached comparator.
   input wire logic sleeping, // Device is in sleep.
   output logic detector_power_enable, // Powers comparator and divider.
   output logic [3:0] trip_level_select, // Divider tap selection.
   output logic use_external_trip, // Routes external pin to comparator.
   output logic low_supply_irq, // Interrupt request to the controller.
   output logic vector_on_wake, // Wake should branch to the vector.
   output logic wake_request // Wake from sleep request.
);
   typedef struct packed
   {
      mon_state_type mon;
      logic [3:0] level;
      logic enable;
      logic stable;
      logic flag;
      logic irq_en;
      logic global_en;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic irq;
      logic vec;
      logic wake;
      logic ext;
   } mon_type;
   mon_type state_r;
   mon_type state_nxt;
   logic settle_done;
   logic access;
   logic [7:0] ctrl_view;
   logic [7:0] irq_view;

   // Timer for the reference start-up wait, restarted at each enable.
   settle_timer #(.cycles(settle_count)) timer_inst
   (
      .clk(clk),
      .reset_n(reset_n),
      .run(state_r.enable),
      .done(settle_done)
   );

   // Register views and the access strobe.
   assign access = psel && penable && !state_r.ready;
   assign ctrl_view = {2'b00, state_r.stable, state_r.enable, state_r.level};
   assign irq_view = {5'b00000, state_r.global_en, state_r.irq_en, state_r.flag};

   // Next state: bus access, settle sequencing, flag and outputs.
   always_comb
   begin
      state_nxt = state_r;
      state_nxt.ready = 1'b0;
      state_nxt.err = 1'b0;
      if (access)
      begin
         state_nxt.ready = 1'b1;
         state_nxt.rdata = '0;
         if (paddr == ctrl_addr)
         begin
            if (pwrite)
            begin
               state_nxt.level = pwdata[level_lsb +: 4];
               state_nxt.enable = pwdata[enable_bit];
            end
            else
            begin
               state_nxt.rdata = {24'h000000, ctrl_view};
            end
         end
         else if (paddr == irq_addr)
         begin
            if (pwrite)
            begin
               // Write one clears the flag; the bits are plain enables.
               if (pwdata[flag_bit])
               begin
                  state_nxt.flag = 1'b0;
               end
               state_nxt.irq_en = pwdata[irq_en_bit];
               state_nxt.global_en = pwdata[global_en_bit];
            end
            else
            begin
               state_nxt.rdata = {24'h000000, irq_view};
            end
         end
         else
         begin
            state_nxt.err = 1'b1;
         end
      end
      // Settle sequencing follows the power enable.
      unique case (state_r.mon)
         mon_off:
         begin
            state_nxt.stable = 1'b0;
            if (state_r.enable)
            begin
               state_nxt.mon = mon_settle;
            end
         end
         mon_settle:
         begin
            state_nxt.stable = 1'b0;
            if (!state_r.enable)
            begin
               state_nxt.mon = mon_off;
            end
            else if (settle_done)
            begin
               state_nxt.mon = mon_ready;
               state_nxt.stable = 1'b1;
            end
         end
         mon_ready:
         begin
            if (!state_r.enable)
            begin
               state_nxt.mon = mon_off;
               state_nxt.stable = 1'b0;
            end
         end
         default:
         begin
            state_nxt.mon = mon_off;
            state_nxt.stable = 1'b0;
         end
      endcase
      // Trip sets the sticky flag, also in sleep; set beats a same-cycle clear.
      if (state_r.enable && state_r.stable && comp_below)
      begin
         state_nxt.flag = 1'b1;
      end
      state_nxt.ext = (state_nxt.level == level_external);
      state_nxt.irq = state_nxt.flag && state_nxt.irq_en;
      state_nxt.wake = state_nxt.flag && state_nxt.irq_en && sleeping;
      state_nxt.vec = state_nxt.irq && state_nxt.global_en;
   end

   // State register; reset leaves the detector powered down.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_r <= '0;
         state_r.mon <= mon_off;
         state_r.level <= level_reset;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // Outputs straight from the state flip-flops.
   assign prdata = state_r.rdata;
   assign pready = state_r.ready;
   assign pslverr = state_r.err;
   assign detector_power_enable = state_r.enable;
   assign trip_level_select = state_r.level;
   assign use_external_trip = state_r.ext;
   assign low_supply_irq = state_r.irq;
   assign vector_on_wake = state_r.vec;
   assign wake_request = state_r.wake;
endmodule

// *** tb/supply_monitor_properties.sv ***
module supply_monitor_properties
   import supply_monitor_pkg::*;
#(parameter logic [settle_width-1:0] settle_count = settle_width'(settle_cycles))
(
   input wire logic clk, // System clock.
   input wire logic reset_n, // Asynchronous reset, active low.
   input wire logic psel, // Bus select.
   input wire logic penable, // Bus access phase.
   input wire logic pwrite, // Bus write.
   input wire logic pready, // Bus ready.
   input wire logic [11:0] paddr, // Byte address.
   input wire logic [31:0] pwdata, // Bus write data.
   input wire logic [31:0] prdata, // Bus read data.
   input wire logic detector_power_enable, // Detector power control.
   input wire logic use_external_trip, // External input route.
   input wire logic low_supply_irq, // Interrupt request.
   input wire logic vector_on_wake, // Vector request.
   input wire logic wake_request, // Wake request.
   input wire logic [3:0] trip_level_select // Tap selection.
);
   timeunit 1ns;
   timeprecision 1ns;
   wire wr = psel && penable && pready && pwrite;
   logic [15:0] en_cnt;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Counts the cycles for which the detector has been powered.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         en_cnt <= '0;
      end
      else
      begin
         en_cnt <= detector_power_enable ? en_cnt + {15'h0, en_cnt != 16'hffff} : '0;
      end
   end
   property p_ready; psel && penable && !pready |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("ready missing");
   property p_level; wr && paddr == ctrl_addr |-> ##2 trip_level_select == $past(pwdata[3:0], 2);
   endproperty
   a_level: assert property (p_level) else $error("level not stored");
   property p_pwr; wr && paddr == ctrl_addr |-> ##2 detector_power_enable == $past(pwdata[4], 2);
   endproperty
   a_pwr: assert property (p_pwr) else $error("enable not stored");
   property p_ext; use_external_trip == (trip_level_select == level_external); endproperty
   a_ext: assert property (p_ext) else $error("external route wrong");
   property p_upper; pready && !pwrite && paddr == ctrl_addr |-> prdata[31:6] == '0; endproperty
   a_upper: assert property (p_upper) else $error("upper bits set");
   property p_settle; pready && !pwrite && paddr == ctrl_addr && prdata[5] |-> en_cnt >= settle_count;
   endproperty
   a_settle: assert property (p_settle) else $error("stable too early");
   property p_hold; $fell(low_supply_irq) |-> wr && paddr == irq_addr; endproperty
   a_hold: assert property (p_hold) else $error("flag dropped alone");
   property p_vec; vector_on_wake |-> low_supply_irq; endproperty
   a_vec: assert property (p_vec) else $error("vector without flag");
   property p_wake; wake_request |-> low_supply_irq; endproperty
   a_wake: assert property (p_wake) else $error("wake without flag");
   property p_reset; disable iff (1'b0) $rose(reset_n) |-> trip_level_select == 4'h5 &&
      !detector_power_enable && !low_supply_irq; endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");
   c_irq: cover property (wr && paddr == irq_addr);
   c_vec: cover property (vector_on_wake);
   c_stable: cover property (pready && prdata[5]);
endmodule
bind supply_monitor supply_monitor_properties #(.settle_count(settle_count)) i_chk
(
   .clk(clk),
   .reset_n(reset_n),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .pready(pready),
   .paddr(paddr),
   .pwdata(pwdata),
   .prdata(prdata),
   .detector_power_enable(detector_power_enable),
   .use_external_trip(use_external_trip),
   .low_supply_irq(low_supply_irq),
   .vector_on_wake(vector_on_wake),
   .wake_request(wake_request),
   .trip_level_select(trip_level_select)
);

// *** tb/supply_monitor_tb_top.sv ***
module supply_monitor_tb_top import supply_monitor_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, comp_below = 0, sleeping = 0;
   logic external_trip_input = 0, pready, pslverr, detector_power_enable, use_external_trip;
   logic low_supply_irq, vector_on_wake, wake_request, rd_err;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd_data;
   logic [3:0] trip_level_select;
   int err_total = 0, checks = 0, cyc = 0;
   supply_monitor #(.settle_count(16'd8)) i_dut
   (
      .clk(clk),
      .reset_n(reset_n),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .comp_below(comp_below),
      .external_trip_input(external_trip_input),
      .sleeping(sleeping),
      .detector_power_enable(detector_power_enable),
      .trip_level_select(trip_level_select),
      .use_external_trip(use_external_trip),
      .low_supply_irq(low_supply_irq),
      .vector_on_wake(vector_on_wake),
      .wake_request(wake_request)
   );
   // Free running clock.
   always #5 clk = ~clk;
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic acc(logic [11:0] a, logic w, logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rd(logic [11:0] a, logic [31:0] e);
      acc(a, 0, 0);
      chk($sformatf("reg_%h", a), e, rd_data);
   endtask
   task automatic pulse;
      comp_below <= 1;
      @(posedge clk);
      comp_below <= 0;
      repeat (6) @(posedge clk);
   endtask
   task end_sim;
      if (err_total == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Cuts a hang short.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         err_total++;
         end_sim;
      end
   end
   // Main sequence of register accesses and comparator events.
   initial
   begin
      repeat (16) @(posedge clk);
      reset_n <= 1;
      rd(ctrl_addr, 32'h05);
      rd(irq_addr, 32'h0);
      acc(12'h008, 1, 32'hff);
      chk("slverr", 1, {31'h0, rd_err});
      for (int c = 13; c < 16; c++)
      begin
         acc(ctrl_addr, 1, 32'he0 | c);
         rd(ctrl_addr, c);
         chk("tap", c, {28'h0, trip_level_select});
         chk("ext", c == 15, {31'h0, use_external_trip});
      end
      comp_below <= 1;
      acc(ctrl_addr, 1, 32'h1e);
      rd(irq_addr, 32'h0);
      rd(ctrl_addr, 32'h1e);
      chk("pwr", 1, {31'h0, detector_power_enable});
      repeat (12) @(posedge clk);
      rd(ctrl_addr, 32'h3e);
      rd(irq_addr, 32'h1);
      comp_below <= 0;
      acc(irq_addr, 1, 32'h1);
      acc(irq_addr, 1, 32'h6);
      rd(irq_addr, 32'h6);
      pulse;
      chk("irq", 1, {31'h0, low_supply_irq});
      chk("vec", 1, {31'h0, vector_on_wake});
      chk("wake", 0, {31'h0, wake_request});
      sleeping <= 1;
      acc(irq_addr, 1, 32'h3);
      pulse;
      chk("wake", 1, {31'h0, wake_request});
      chk("vec", 0, {31'h0, vector_on_wake});
      acc(irq_addr, 1, 32'h3);
      acc(ctrl_addr, 1, 32'h0e);
      comp_below <= 1;
      repeat (6) @(posedge clk);
      rd(irq_addr, 32'h2);
      rd(ctrl_addr, 32'h0e);
      reset_n <= 0;
      repeat (2) @(posedge clk);
      reset_n <= 1;
      rd(ctrl_addr, 32'h05);
      rd(irq_addr, 32'h0);
      end_sim;
   end
endmodule
